/* File: core/tcp_pkg.sv */
// Package for the timer compare, one-pulse and PWM block
package tcp_pkg;
  localparam logic [3:0]  TCP_OFS_CTRL1    = 4'h0;
  localparam logic [3:0]  TCP_OFS_CTRL2    = 4'h1;
  localparam logic [3:0]  TCP_OFS_STATUS   = 4'h2;
  localparam logic [3:0]  TCP_OFS_CMP1_HI  = 4'h3;
  localparam logic [3:0]  TCP_OFS_CMP1_LO  = 4'h4;
  localparam logic [3:0]  TCP_OFS_CMP2_HI  = 4'h5;
  localparam logic [3:0]  TCP_OFS_CMP2_LO  = 4'h6;
  localparam logic [3:0]  TCP_OFS_CAP1_HI  = 4'h7;
  localparam logic [3:0]  TCP_OFS_CAP1_LO  = 4'h8;
  localparam logic [3:0]  TCP_OFS_CAP2_HI  = 4'h9;
  localparam logic [3:0]  TCP_OFS_CAP2_LO  = 4'ha;
  localparam logic [3:0]  TCP_OFS_CNT_HI   = 4'hb;
  localparam logic [3:0]  TCP_OFS_CNT_LO   = 4'hc;
  // Control-1 bit positions
  localparam int          TCP_C1_CAP_IE    = 7;
  localparam int          TCP_C1_CMP_IE    = 6;
  localparam int          TCP_C1_FORCE2    = 4;
  localparam int          TCP_C1_FORCE1    = 3;
  localparam int          TCP_C1_LEVEL2    = 2;
  localparam int          TCP_C1_EDGE1     = 1;
  localparam int          TCP_C1_LEVEL1    = 0;
  // Control-2 bit positions
  localparam int          TCP_C2_PIN1_EN   = 7;
  localparam int          TCP_C2_PIN2_EN   = 6;
  localparam int          TCP_C2_ONE_PULSE = 5;
  localparam int          TCP_C2_PWM       = 4;
  localparam int          TCP_C2_TICK_HI   = 3;
  localparam int          TCP_C2_TICK_LO   = 2;
  localparam int          TCP_C2_EDGE2     = 1;
  localparam int          TCP_C2_EXT_EDGE  = 0;
  // Status bit positions
  localparam int          TCP_ST_CAP1      = 7;
  localparam int          TCP_ST_CMP1      = 6;
  localparam int          TCP_ST_CAP2      = 4;
  localparam int          TCP_ST_CMP2      = 3;
  // Reset, reload and one-pulse capture values
  localparam logic [15:0] TCP_CMP_RESET    = 16'h8000;
  localparam logic [15:0] TCP_CNT_RELOAD   = 16'hfffc;
  localparam logic [15:0] TCP_CAP_PULSE    = 16'hfffd;
  localparam logic [7:0]  TCP_CTRL_RESET   = 8'h00;
  // Tick dividers
  localparam logic [2:0]  TCP_DIV2_MASK    = 3'h1;
  localparam logic [2:0]  TCP_DIV4_MASK    = 3'h3;
  localparam logic [2:0]  TCP_DIV8_MASK    = 3'h7;

  typedef enum logic [1:0] {TCP_SRC_DIV4, TCP_SRC_DIV2, TCP_SRC_DIV8, TCP_SRC_EXT} tcp_src_e;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tcp_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } tcp_bus_rsp_s;

  typedef struct packed {
    logic out_val;
    logic out_en_n;
  } tcp_pin_s;
endpackage

/* File: core/tcp_timer.sv */
// Output compare, one-pulse and PWM timer with Avalon-MM registers
// Notes on behaviour
// - Match sets flag, drives level, requests interrupt
// - Two 16-bit compare values, hardware never changes
// - Reset loads compare values with 8000h
// - Compare pin latch low during reset
// - Flag clears after status read then low access
// - High byte write suspends compare until low
// - Pin disabled: no drive, flag still works
// - Divide-by-two matches equal, others plus one
// - Force copies level bit to pin immediately
// - Force ignored in one-pulse or PWM mode
// - One-pulse select enables one-pulse mode
// - Capture edge reloads counter, starts pulse
// - Compare one match ends the pulse
// - One-pulse never sets first match flag
// - Both selects set means PWM only
// - First capture pin idle in PWM mode only
// - Second compare only sets its flag in one-pulse
// - PWM compare values load at period end
// - PWM pin takes level one, then two
// - PWM second match reloads counter FFFCh
// - PWM never sets match flags
// - PWM period end sets first capture flag
// - Pin enable gates only the pin
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcp_timer
  import tcp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire tcp_pkg::tcp_bus_req_s bus_req,
  output tcp_pkg::tcp_bus_rsp_s      bus_rsp,
  input  wire logic                  capture_pin_one,
  input  wire logic                  capture_pin_two,
  input  wire logic                  ext_clk_pin,
  input  wire logic                  cpu_irq_mask,
  output tcp_pkg::tcp_pin_s          compare_output_pin_one,
  output tcp_pkg::tcp_pin_s          compare_output_pin_two,
  output logic                       timer_irq
);
  import tcp_pkg::*;

  logic [7:0]  ctrl1_ff;
  logic [7:0]  ctrl2_ff;
  logic [15:0] cmp_ff [2];
  logic [15:0] cmp_act_ff [2];
  logic [1:0]  cmp_hold_ff;
  logic [7:0]  cmp_hi_buf_ff [2];
  logic [15:0] cnt_ff;
  logic [15:0] cap_ff [2];
  logic [1:0]  cap_hold_ff;
  logic [1:0]  match_flag_ff;
  logic [1:0]  cap_flag_ff;
  logic [1:0]  match_seen_ff;
  logic [1:0]  cap_seen_ff;
  logic [1:0]  pin_lat_ff;
  logic [2:0]  pre_ff;
  logic        cap1_pin_ff;
  logic        cap2_pin_ff;
  logic        ext_pin_ff;
  logic [31:0] rdata_ff;
  logic        ack_ff;

  logic        tick;
  logic        pwm_mode;
  logic        opm_mode;
  logic        plus_one;
  logic [1:0]  hit;
  logic        cap1_edge;
  logic        cap2_edge;
  logic        rd_acc;
  logic        wr_acc;
  logic [7:0]  wbyte;
  logic [15:0] nxt_cnt;

  function automatic logic edge_hit(input logic prev, input logic now, input logic rising);
    edge_hit = rising ? (!prev && now) : (prev && !now);
  endfunction

  function automatic logic lo_access(input logic [3:0] a, input logic [3:0] ofs, input logic acc);
    lo_access = acc && (a == ofs);
  endfunction

  assign pwm_mode = ctrl2_ff[TCP_C2_PWM];
  assign opm_mode = ctrl2_ff[TCP_C2_ONE_PULSE] && !pwm_mode;
  assign wbyte    = bus_req.writedata[7:0];
  assign rd_acc   = bus_req.read && !ack_ff;
  assign wr_acc   = bus_req.write && !ack_ff;

  // Tick from prescaler or external edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_ff <= 3'h0;
    end else begin
      pre_ff <= pre_ff + 3'h1;
    end
  end

  // Pin history follows the pins in reset too, so no false edge after release
  always_ff @(posedge clk) begin
    ext_pin_ff  <= ext_clk_pin;
    cap1_pin_ff <= capture_pin_one;
    cap2_pin_ff <= capture_pin_two;
  end

  always_comb begin
    unique case (tcp_src_e'(ctrl2_ff[TCP_C2_TICK_HI:TCP_C2_TICK_LO]))
      TCP_SRC_DIV2: tick = (pre_ff & TCP_DIV2_MASK) == TCP_DIV2_MASK;
      TCP_SRC_DIV4: tick = (pre_ff & TCP_DIV4_MASK) == TCP_DIV4_MASK;
      TCP_SRC_DIV8: tick = (pre_ff & TCP_DIV8_MASK) == TCP_DIV8_MASK;
      TCP_SRC_EXT:  tick = edge_hit(ext_pin_ff, ext_clk_pin, ctrl2_ff[TCP_C2_EXT_EDGE]);
    endcase
  end

  // Divide-by-two compares the count itself, other sources the count minus one
  assign plus_one  = tcp_src_e'(ctrl2_ff[TCP_C2_TICK_HI:TCP_C2_TICK_LO]) != TCP_SRC_DIV2;
  assign cap1_edge = edge_hit(cap1_pin_ff, capture_pin_one, ctrl1_ff[TCP_C1_EDGE1]);
  assign cap2_edge = edge_hit(cap2_pin_ff, capture_pin_two, ctrl2_ff[TCP_C2_EDGE2]);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      hit[i] = tick && !cmp_hold_ff[i] &&
               (cnt_ff == cmp_act_ff[i] + (plus_one ? 16'h0001 : 16'h0000));
    end
  end

  // Free-running counter with reloads
  always_comb begin
    nxt_cnt = cnt_ff;
    if (tick) begin
      nxt_cnt = cnt_ff + 16'h0001;
    end
    if (pwm_mode && hit[1]) begin
      nxt_cnt = TCP_CNT_RELOAD;
    end
    if (opm_mode && cap1_edge) begin
      nxt_cnt = TCP_CNT_RELOAD;
    end
    if (wr_acc && bus_req.address == TCP_OFS_CNT_LO) begin
      nxt_cnt = TCP_CNT_RELOAD;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= TCP_CNT_RELOAD;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl1_ff <= TCP_CTRL_RESET;
      ctrl2_ff <= TCP_CTRL_RESET;
    end else if (wr_acc) begin
      if (bus_req.address == TCP_OFS_CTRL1) begin
        ctrl1_ff <= wbyte;
      end
      if (bus_req.address == TCP_OFS_CTRL2) begin
        ctrl2_ff <= wbyte;
      end
    end
  end

  // Compare values, high byte held until the low byte completes the pair
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        cmp_ff[i]        <= TCP_CMP_RESET;
        cmp_act_ff[i]    <= TCP_CMP_RESET;
        cmp_hi_buf_ff[i] <= TCP_CMP_RESET[15:8];
      end
      cmp_hold_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_acc && bus_req.address == (i == 0 ? TCP_OFS_CMP1_HI : TCP_OFS_CMP2_HI)) begin
          cmp_hi_buf_ff[i] <= wbyte;
          cmp_hold_ff[i]   <= 1'b1;
        end
        if (wr_acc && bus_req.address == (i == 0 ? TCP_OFS_CMP1_LO : TCP_OFS_CMP2_LO)) begin
          cmp_ff[i]      <= {cmp_hold_ff[i] ? cmp_hi_buf_ff[i] : cmp_ff[i][15:8], wbyte};
          cmp_hold_ff[i] <= 1'b0;
        end
      end
      if (pwm_mode) begin
        if (hit[1]) begin
          cmp_act_ff[0] <= cmp_ff[0];
          cmp_act_ff[1] <= cmp_ff[1];
        end
      end else begin
        cmp_act_ff[0] <= cmp_ff[0];
        cmp_act_ff[1] <= cmp_ff[1];
      end
    end
  end

  // Match flags with two-step clear; a new match wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      match_flag_ff <= 2'b00;
      match_seen_ff <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd_acc && bus_req.address == TCP_OFS_STATUS) begin
          match_seen_ff[i] <= match_flag_ff[i];
        end
        if (lo_access(bus_req.address, i == 0 ? TCP_OFS_CMP1_LO : TCP_OFS_CMP2_LO,
                      rd_acc || wr_acc) && match_seen_ff[i]) begin
          match_flag_ff[i] <= 1'b0;
          match_seen_ff[i] <= 1'b0;
        end
        if (hit[i] && !pwm_mode && !(opm_mode && i == 0)) begin
          match_flag_ff[i] <= 1'b1;
        end
      end
    end
  end

  // Capture flags and values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cap_flag_ff <= 2'b00;
      cap_seen_ff <= 2'b00;
      cap_hold_ff <= 2'b00;
      cap_ff[0]   <= 16'h0000;
      cap_ff[1]   <= 16'h0000;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (rd_acc && bus_req.address == TCP_OFS_STATUS) begin
          cap_seen_ff[i] <= cap_flag_ff[i];
        end
        if (rd_acc && bus_req.address == (i == 0 ? TCP_OFS_CAP1_HI : TCP_OFS_CAP2_HI)) begin
          cap_hold_ff[i] <= 1'b1;
        end
        if (lo_access(bus_req.address, i == 0 ? TCP_OFS_CAP1_LO : TCP_OFS_CAP2_LO,
                      rd_acc || wr_acc)) begin
          cap_hold_ff[i] <= 1'b0;
          if (cap_seen_ff[i]) begin
            cap_flag_ff[i] <= 1'b0;
            cap_seen_ff[i] <= 1'b0;
          end
        end
      end
      if (cap2_edge && !cap_hold_ff[1]) begin
        cap_ff[1]      <= cnt_ff;
        cap_flag_ff[1] <= 1'b1;
      end
      if (pwm_mode) begin
        if (hit[1]) begin
          cap_flag_ff[0] <= 1'b1;
        end
      end else if (opm_mode) begin
        if (cap1_edge) begin
          cap_ff[0]      <= TCP_CAP_PULSE;
          cap_flag_ff[0] <= 1'b1;
        end
      end else if (cap1_edge && !cap_hold_ff[0]) begin
        cap_ff[0]      <= cnt_ff;
        cap_flag_ff[0] <= 1'b1;
      end
    end
  end

  // Pin latches, low while reset is held
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_lat_ff <= 2'b00;
    end else if (pwm_mode) begin
      if (hit[1]) begin
        pin_lat_ff[0] <= ctrl1_ff[TCP_C1_LEVEL2];
      end else if (hit[0]) begin
        pin_lat_ff[0] <= ctrl1_ff[TCP_C1_LEVEL1];
      end
    end else if (opm_mode) begin
      if (cap1_edge) begin
        pin_lat_ff[0] <= ctrl1_ff[TCP_C1_LEVEL2];
      end else if (hit[0]) begin
        pin_lat_ff[0] <= ctrl1_ff[TCP_C1_LEVEL1];
      end
    end else begin
      if (ctrl1_ff[TCP_C1_FORCE1] || hit[0]) begin
        pin_lat_ff[0] <= ctrl1_ff[TCP_C1_LEVEL1];
      end
      if (ctrl1_ff[TCP_C1_FORCE2] || hit[1]) begin
        pin_lat_ff[1] <= ctrl1_ff[TCP_C1_LEVEL2];
      end
    end
  end

  // Pin enables gate only the pin drive
  assign compare_output_pin_one.out_val  = pin_lat_ff[0];
  assign compare_output_pin_one.out_en_n = !ctrl2_ff[TCP_C2_PIN1_EN];
  assign compare_output_pin_two.out_val  = pin_lat_ff[1];
  assign compare_output_pin_two.out_en_n = !ctrl2_ff[TCP_C2_PIN2_EN] || opm_mode || pwm_mode;

  assign timer_irq = !cpu_irq_mask &&
                     ((ctrl1_ff[TCP_C1_CMP_IE] && |match_flag_ff) ||
                      (ctrl1_ff[TCP_C1_CAP_IE] && |cap_flag_ff));

  // Avalon slave, one wait state per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= (bus_req.read || bus_req.write) && !ack_ff;
      if (rd_acc) begin
        unique case (bus_req.address)
          TCP_OFS_CTRL1:   rdata_ff <= {24'h000000, ctrl1_ff};
          TCP_OFS_CTRL2:   rdata_ff <= {24'h000000, ctrl2_ff};
          TCP_OFS_STATUS:  rdata_ff <= {24'h000000, cap_flag_ff[0], match_flag_ff[0], 1'b0,
                                        cap_flag_ff[1], match_flag_ff[1], 3'h0};
          TCP_OFS_CMP1_HI: rdata_ff <= {24'h000000, cmp_ff[0][15:8]};
          TCP_OFS_CMP1_LO: rdata_ff <= {24'h000000, cmp_ff[0][7:0]};
          TCP_OFS_CMP2_HI: rdata_ff <= {24'h000000, cmp_ff[1][15:8]};
          TCP_OFS_CMP2_LO: rdata_ff <= {24'h000000, cmp_ff[1][7:0]};
          TCP_OFS_CAP1_HI: rdata_ff <= {24'h000000, cap_ff[0][15:8]};
          TCP_OFS_CAP1_LO: rdata_ff <= {24'h000000, cap_ff[0][7:0]};
          TCP_OFS_CAP2_HI: rdata_ff <= {24'h000000, cap_ff[1][15:8]};
          TCP_OFS_CAP2_LO: rdata_ff <= {24'h000000, cap_ff[1][7:0]};
          TCP_OFS_CNT_HI:  rdata_ff <= {24'h000000, cnt_ff[15:8]};
          TCP_OFS_CNT_LO:  rdata_ff <= {24'h000000, cnt_ff[7:0]};
          default:         rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign bus_rsp.waitrequest = (bus_req.read || bus_req.write) && !ack_ff;
  assign bus_rsp.readdata    = rdata_ff;
endmodule
`default_nettype wire

/* File: verif/tcp_pins_model.sv */
// Far-side model driving the capture and external tick pins
`timescale 1ns/1ps
`default_nettype none
module tcp_pins_model (
  input  wire logic clk,
  input  wire logic fire_one,
  output var logic  capture_pin_one,
  output var logic  capture_pin_two,
  output var logic  ext_clk_pin
);
  logic [2:0] div_ff;
  initial begin
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b1;
    ext_clk_pin = 1'b0;
    div_ff = 3'h0;
  end
  // Slow external edges, far below a quarter of the clock
  always @(posedge clk) begin
    div_ff <= div_ff + 3'h1;
    if (div_ff == 3'h7) ext_clk_pin <= !ext_clk_pin;
    if (fire_one) capture_pin_one <= !capture_pin_one;
  end
endmodule
`default_nettype wire

/* File: verif/tcp_timer_checker.sv */
// Port checker for the compare timer
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_checker
  import tcp_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire tcp_pkg::tcp_bus_req_s bus_req,
  input wire tcp_pkg::tcp_bus_rsp_s bus_rsp,
  input wire logic                  capture_pin_one,
  input wire logic                  capture_pin_two,
  input wire logic                  ext_clk_pin,
  input wire logic                  cpu_irq_mask,
  input wire tcp_pkg::tcp_pin_s     compare_output_pin_one,
  input wire tcp_pkg::tcp_pin_s     compare_output_pin_two,
  input wire logic                  timer_irq
);
  logic [7:0] c1_ff;
  logic [7:0] c2_ff;
  logic       req;
  logic       f1;
  logic       spec;
  assign req = bus_req.read || bus_req.write;
  assign spec = c2_ff[TCP_C2_ONE_PULSE] || c2_ff[TCP_C2_PWM];
  assign f1 = c1_ff[TCP_C1_FORCE1] && c2_ff[TCP_C2_PIN1_EN] && !spec;
  // Shadow of the control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      c1_ff <= TCP_CTRL_RESET;
      c2_ff <= TCP_CTRL_RESET;
    end else if (bus_req.write && bus_rsp.waitrequest) begin
      if (bus_req.address == TCP_OFS_CTRL1) c1_ff <= bus_req.writedata[7:0];
      if (bus_req.address == TCP_OFS_CTRL2) c2_ff <= bus_req.writedata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    req && bus_rsp.waitrequest;
  endsequence
  sequence s_done;
    bus_req.read && !bus_rsp.waitrequest;
  endsequence
  AST_RST_PIN: assert property ($rose(rst_n) |-> !compare_output_pin_one.out_val &&
    !compare_output_pin_two.out_val) else $error("compare pin not low after reset");
  AST_WAIT: assert property (s_taken |=> !bus_rsp.waitrequest)
    else $error("no answer one cycle after request");
  AST_WAIT_FIRST: assert property (req && !$past(req) |-> bus_rsp.waitrequest)
    else $error("no wait state on new request");
  AST_UNMAPPED: assert property ((s_done and bus_req.address > TCP_OFS_CNT_LO) |-> bus_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  AST_UPPER: assert property (s_done |-> bus_rsp.readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_IRQ_MASK: assert property (cpu_irq_mask |-> !timer_irq)
    else $error("irq while masked");
  AST_IRQ_OFF: assert property (!c1_ff[TCP_C1_CAP_IE] && !c1_ff[TCP_C1_CMP_IE] |-> !timer_irq)
    else $error("irq with enables clear");
  AST_PIN1_EN: assert property (compare_output_pin_one.out_en_n == !c2_ff[TCP_C2_PIN1_EN])
    else $error("pin one enable wrong");
  AST_PIN2_EN: assert property (compare_output_pin_two.out_en_n == !(c2_ff[TCP_C2_PIN2_EN] && !spec))
    else $error("pin two enable wrong");
  AST_FORCE: assert property (f1 |=> compare_output_pin_one.out_val == $past(c1_ff[TCP_C1_LEVEL1]))
    else $error("forced pin not following level");
endmodule
`default_nettype wire

/* File: verif/tcp_timer_tb_top.sv */
// Testbench for the compare, one-pulse and PWM timer
`timescale 1ns/1ps
`default_nettype none
module tcp_timer_tb_top;
  import tcp_pkg::*;
  logic         clk;
  logic         rst_n;
  tcp_bus_req_s req;
  tcp_bus_rsp_s rsp;
  logic         cap1;
  logic         cap2;
  logic         xclk;
  logic         mask;
  logic         fire;
  tcp_pin_s     p1;
  tcp_pin_s     p2;
  logic         irq;
  logic [7:0]   q;
  int           err_count;
  int           tests_run;
  tcp_timer dut (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rsp(rsp), .capture_pin_one(cap1),
    .capture_pin_two(cap2), .ext_clk_pin(xclk), .cpu_irq_mask(mask), .compare_output_pin_one(p1),
    .compare_output_pin_two(p2), .timer_irq(irq));
  tcp_pins_model u_pins (.clk(clk), .fire_one(fire), .capture_pin_one(cap1), .capture_pin_two(cap2),
    .ext_clk_pin(xclk));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One bus access, held until waitrequest low
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    q = rsp.readdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
    if (n >= 20) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chkp(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  // Bounded wait for pin one level
  task automatic wpin(input logic v);
    int n;
    n = 0;
    while (p1.out_val !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chkp("pin one level", v, p1.out_val);
    if (n >= 3000) print_verdict();
  endtask
  initial begin
    rst_n = 1'b0;
    req = '0;
    mask = 1'b1;
    fire = 1'b0;
    err_count = 0;
    tests_run = 0;
    q = 8'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    acc(0, TCP_OFS_CMP1_HI, 8'h0);
    chk("cmp1 hi", 8'h80, q);
    acc(0, TCP_OFS_CMP2_LO, 8'h0);
    chk("cmp2 lo", 8'h00, q);
    chkp("pin1 reset", 1'b0, p1.out_val);
    $display("test reset done");
    acc(1, TCP_OFS_CMP2_HI, 8'h5a);
    acc(1, TCP_OFS_CMP2_LO, 8'ha5);
    acc(0, TCP_OFS_CMP2_HI, 8'h0);
    chk("cmp2 hi", 8'h5a, q);
    acc(1, 4'hd, 8'hff);
    acc(0, 4'hd, 8'h0);
    chk("unmapped", 8'h00, q);
    $display("test access done");
    acc(1, TCP_OFS_CMP1_HI, 8'h00);
    acc(1, TCP_OFS_CMP1_LO, 8'h10);
    acc(1, TCP_OFS_CTRL1, 8'h01);
    acc(1, TCP_OFS_CTRL2, 8'h84);
    acc(1, TCP_OFS_CNT_LO, 8'h0);
    wpin(1'b1);
    acc(0, TCP_OFS_CMP1_LO, 8'h0);
    acc(1, TCP_OFS_CTRL1, 8'h41);
    chkp("irq masked", 1'b0, irq);
    mask <= 1'b0;
    @(posedge clk);
    chkp("irq on", 1'b1, irq);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("match1 kept", 8'h40, q & 8'h40);
    acc(0, TCP_OFS_CMP1_LO, 8'h0);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("match1 clear", 8'h00, q & 8'h40);
    chkp("irq off", 1'b0, irq);
    $display("test match done");
    acc(1, TCP_OFS_CMP2_HI, 8'h00);
    acc(1, TCP_OFS_CMP2_LO, 8'h20);
    acc(1, TCP_OFS_CTRL2, 8'h04);
    acc(1, TCP_OFS_CMP2_HI, 8'h00);
    acc(1, TCP_OFS_CNT_LO, 8'h0);
    repeat (150) @(posedge clk);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("suspended", 8'h00, q & 8'h08);
    acc(1, TCP_OFS_CMP2_LO, 8'h20);
    acc(1, TCP_OFS_CNT_LO, 8'h0);
    repeat (150) @(posedge clk);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("match2 set", 8'h08, q & 8'h08);
    chkp("pin2 free", 1'b1, p2.out_en_n);
    $display("test suspend done");
    acc(0, TCP_OFS_CMP1_LO, 8'h0);
    acc(1, TCP_OFS_CTRL2, 8'h84);
    acc(1, TCP_OFS_CTRL1, 8'h08);
    wpin(1'b0);
    acc(1, TCP_OFS_CTRL1, 8'h09);
    wpin(1'b1);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("force no flag", 8'h00, q & 8'h40);
    acc(1, TCP_OFS_CTRL1, 8'h08);
    wpin(1'b0);
    $display("test force done");
    acc(1, TCP_OFS_CMP1_LO, 8'h40);
    acc(1, TCP_OFS_CTRL1, 8'h06);
    acc(1, TCP_OFS_CTRL2, 8'ha4);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    wpin(1'b1);
    acc(0, TCP_OFS_CAP1_HI, 8'h0);
    chk("cap1 hi", 8'hff, q);
    acc(0, TCP_OFS_CAP1_LO, 8'h0);
    chk("cap1 lo", 8'hfd, q);
    wpin(1'b0);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("pulse flags", 8'h88, q & 8'hc8);
    $display("test pulse done");
    acc(0, TCP_OFS_CAP1_LO, 8'h0);
    acc(1, TCP_OFS_CMP2_LO, 8'h30);
    acc(1, TCP_OFS_CMP1_LO, 8'h10);
    acc(1, TCP_OFS_CTRL1, 8'h01);
    acc(1, TCP_OFS_CTRL2, 8'hb4);
    acc(1, TCP_OFS_CNT_LO, 8'h0);
    wpin(1'b1);
    wpin(1'b0);
    wpin(1'b1);
    acc(0, TCP_OFS_STATUS, 8'h0);
    chk("pwm flags", 8'h80, q & 8'hc8);
    acc(1, TCP_OFS_CTRL1, 8'h81);
    chkp("pwm irq", 1'b1, irq);
    $display("test pwm done");
    acc(1, TCP_OFS_CTRL2, 8'h88);
    acc(1, TCP_OFS_CTRL1, 8'h08);
    acc(1, TCP_OFS_CMP1_LO, 8'h04);
    acc(1, TCP_OFS_CNT_LO, 8'h0);
    wpin(1'b0);
    acc(1, TCP_OFS_CTRL1, 8'h01);
    wpin(1'b1);
    acc(0, TCP_OFS_CNT_LO, 8'h0);
    chk("count after slow match", 8'h06, q);
    $display("test slow tick done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chkp("pin1 in reset", 1'b0, p1.out_val);
    @(posedge clk);
    rst_n <= 1'b1;
    acc(0, TCP_OFS_CMP1_HI, 8'h0);
    chk("cmp1 hi after reset", 8'h80, q);
    $display("test reset again done");
    print_verdict();
  end
endmodule
bind tcp_timer tcp_timer_checker u_chk (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp),
  .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two), .ext_clk_pin(ext_clk_pin),
  .cpu_irq_mask(cpu_irq_mask), .compare_output_pin_one(compare_output_pin_one),
  .compare_output_pin_two(compare_output_pin_two), .timer_irq(timer_irq));
`default_nettype wire
